//--- shared/osdsc_cfg.svh
// Offsets, field positions, reset values and widths of the soft-scroll block
// Overview of operation
// - Top row advances at once when scroll finishes
// - Active flag clears one field later, two fields later in frame mode
// - Stop takes effect at field end only
// - Stop clears active, top row plus one
// - Start ignored until previous stop completed
// - Char after double attribute ignores foreground
// - Double-height shadow draws north shadow last line
`ifndef OSDSC_CFG_SVH
`define OSDSC_CFG_SVH
`define OSDSC_ADDR_W 12
`define OSDSC_OFF_STATUS 12'h000
`define OSDSC_OFF_CTRL 12'h004
`define OSDSC_OFF_RANGE 12'h008
`define OSDSC_OFF_OFFSET 12'h00C
`define OSDSC_STOP_CODE 8'h20
`define OSDSC_BIT_ACTIVE 4
`define OSDSC_BIT_STOP 5
`define OSDSC_BIT_START 6
`define OSDSC_BIT_LOAD 7
`define OSDSC_ROW_W 4
`define OSDSC_BIT_FRAME 4
`define OSDSC_FG_LSB 8
`define OSDSC_CTRL_RESET 32'h0000_0F09
`define OSDSC_RANGE_RESET 8'hF0
`endif

//--- shared/osdsc_pkg.sv
// Types shared by the soft-scroll block
package osdsc_pkg;
	// Scroll sequencer states
	typedef enum logic [1:0] {
		SC_IDLE,
		SC_RUN,
		SC_LINGER
	} osdsc_state_type;
	// Character attributes entering the render stage
	typedef struct packed {
		logic is_attr;
		logic dbl_size;
		logic dbl_width;
		logic dbl_height;
		logic shadow;
		logic underline;
		logic [3:0] fg;
	} osdsc_char_type;
	// Render stage result
	typedef struct packed {
		logic valid;
		logic [3:0] fg;
		logic north_shadow;
		logic underline;
	} osdsc_pix_type;
endpackage : osdsc_pkg

//--- core/osdsc_top.sv
// Soft-scroll control with APB registers, sync pacing and attribute render
//
// The register offsets and the APB interface to the registers were left to the implementer.
`timescale 1ns/1ps
`include "osdsc_cfg.svh"
module osdsc_top (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [`OSDSC_ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Video sync, taken as synchronous
	input wire logic hsync,
	input wire logic vsync,
	// Character stream
	input wire logic char_valid,
	input wire osdsc_pkg::osdsc_char_type char_in,
	// Display position and pixel result
	output logic [`OSDSC_ROW_W-1:0] disp_row,
	output logic [`OSDSC_ROW_W-1:0] disp_line,
	output logic scroll_active,
	output osdsc_pkg::osdsc_pix_type pix_out
);

	// Bus registers
	logic [31:0] prdata_q, prdata_d;
	logic pready_q, pready_d;
	logic pslverr_q, pslverr_d;
	logic [31:0] ctrl_q, ctrl_d;
	logic [7:0] range_q, range_d;
	// Scroll state
	osdsc_pkg::osdsc_state_type state_q, state_d;
	logic [`OSDSC_ROW_W-1:0] top_q, top_d;
	logic [`OSDSC_ROW_W-1:0] offs_q, offs_d;
	logic stop_pend_q, stop_pend_d;
	logic active_q, active_d;
	logic parity_q, parity_d;
	// Sync edge memory
	logic hs_q, vs_q;
	// Position counters
	logic [`OSDSC_ROW_W-1:0] row_q, row_d;
	logic [`OSDSC_ROW_W-1:0] line_q, line_d;
	// Render state
	logic after_dbl_q, after_dbl_d;
	osdsc_pkg::osdsc_pix_type pix_q, pix_d;

	// Decoded fields
	logic acc_done;
	logic wr_status;
	logic start_cmd;
	logic stop_cmd;
	logic load_cmd;
	logic hs_edge;
	logic vs_edge;
	logic field_tick;
	logic [`OSDSC_ROW_W-1:0] lpr;
	logic [`OSDSC_ROW_W-1:0] first_row;
	logic [`OSDSC_ROW_W-1:0] last_row;
	logic frame_mode;
	logic [3:0] dflt_fg;

	// Completion of an access at this edge
	assign acc_done = psel & penable & pready_q;
	assign wr_status = acc_done & pwrite & (paddr == `OSDSC_OFF_STATUS);
	// Stop is the exact code, start and load are own bits
	assign stop_cmd = wr_status & (pwdata[7:0] == `OSDSC_STOP_CODE);
	assign start_cmd = wr_status & pwdata[`OSDSC_BIT_START];
	assign load_cmd = wr_status & pwdata[`OSDSC_BIT_LOAD];
	// Configuration fields
	assign lpr = ctrl_q[`OSDSC_ROW_W-1:0];
	assign frame_mode = ctrl_q[`OSDSC_BIT_FRAME];
	assign dflt_fg = ctrl_q[`OSDSC_FG_LSB+3:`OSDSC_FG_LSB];
	assign first_row = range_q[3:0];
	assign last_row = range_q[7:4];
	// Rising sync edges
	assign hs_edge = hsync & ~hs_q;
	assign vs_edge = vsync & ~vs_q;
	// In frame mode only every second field paces the scroll
	assign field_tick = vs_edge & (~frame_mode | parity_q);

	// Next row inside the scroll range, wrapping at its end
	function automatic logic [`OSDSC_ROW_W-1:0] next_row(
		input logic [`OSDSC_ROW_W-1:0] r,
		input logic [`OSDSC_ROW_W-1:0] lo,
		input logic [`OSDSC_ROW_W-1:0] hi
	);
		next_row = (r == hi) ? lo : r + 4'h1;
	endfunction : next_row

	// APB decode and register writes
	always_comb begin
		prdata_d = prdata_q;
		pready_d = psel & penable & ~pready_q;
		pslverr_d = 1'b0;
		ctrl_d = ctrl_q;
		range_d = range_q;
		// Read data prepared in the wait cycle
		if (psel & penable & ~pready_q) begin
			prdata_d = 32'h0000_0000;
			unique case (paddr)
				`OSDSC_OFF_STATUS: begin
					// Flag and row stay visible at all times
					prdata_d[`OSDSC_BIT_ACTIVE] = active_q;
					prdata_d[`OSDSC_ROW_W-1:0] = top_q;
				end
				`OSDSC_OFF_CTRL: begin
					prdata_d = ctrl_q;
				end
				`OSDSC_OFF_RANGE: begin
					prdata_d[7:0] = range_q;
				end
				`OSDSC_OFF_OFFSET: begin
					prdata_d[`OSDSC_ROW_W-1:0] = offs_q;
				end
				default: begin
					// Unmapped offsets answer with an error
					pslverr_d = 1'b1;
				end
			endcase
		end
		// Writes land on the completing edge only
		if (acc_done & pwrite) begin
			if (paddr == `OSDSC_OFF_CTRL) begin
				ctrl_d = pwdata & 32'h0000_0F1F;
			end
			if (paddr == `OSDSC_OFF_RANGE) begin
				range_d = pwdata[7:0];
			end
		end
	end

	// APB registers
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			prdata_q <= 32'h0000_0000;
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
			ctrl_q <= `OSDSC_CTRL_RESET;
			range_q <= `OSDSC_RANGE_RESET;
		end else begin
			prdata_q <= prdata_d;
			pready_q <= pready_d;
			pslverr_q <= pslverr_d;
			ctrl_q <= ctrl_d;
			range_q <= range_d;
		end
	end

	// Scroll sequencer
	always_comb begin
		state_d = state_q;
		top_d = top_q;
		offs_d = offs_q;
		stop_pend_d = stop_pend_q;
		active_d = active_q;
		parity_d = vs_edge ? ~parity_q : parity_q;
		unique case (state_q)
			osdsc_pkg::SC_IDLE: begin
				// Row can only be loaded while nothing moves
				if (load_cmd) begin
					top_d = pwdata[`OSDSC_ROW_W-1:0];
				end
				// Start accepted only once fully stopped
				if (start_cmd) begin
					state_d = osdsc_pkg::SC_RUN;
					active_d = 1'b1;
					offs_d = 4'h0;
					stop_pend_d = 1'b0;
				end
			end
			osdsc_pkg::SC_RUN: begin
				// Stop waits for the field boundary
				if (stop_cmd) begin
					stop_pend_d = 1'b1;
				end
				if (field_tick) begin
					if (stop_pend_q | stop_cmd) begin
						// Halt: flag drops, base moves one row
						state_d = osdsc_pkg::SC_IDLE;
						active_d = 1'b0;
						top_d = next_row(top_q, first_row, last_row);
						offs_d = 4'h0;
						stop_pend_d = 1'b0;
					end else if (offs_q == lpr) begin
						// Row done: base moves now, flag lingers
						top_d = next_row(top_q, first_row, last_row);
						offs_d = 4'h0;
						state_d = osdsc_pkg::SC_LINGER;
					end else begin
						offs_d = offs_q + 4'h1;
					end
				end
			end
			osdsc_pkg::SC_LINGER: begin
				// Flag clears at the next paced field after the row update, two fields later in frame mode
				if (field_tick) begin
					active_d = 1'b0;
					state_d = osdsc_pkg::SC_IDLE;
				end
			end
		endcase
	end

	// Sequencer registers
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			state_q <= osdsc_pkg::SC_IDLE;
			top_q <= 4'h0;
			offs_q <= 4'h0;
			stop_pend_q <= 1'b0;
			active_q <= 1'b0;
			parity_q <= 1'b0;
		end else begin
			state_q <= state_d;
			top_q <= top_d;
			offs_q <= offs_d;
			stop_pend_q <= stop_pend_d;
			active_q <= active_d;
			parity_q <= parity_d;
		end
	end

	// Display position counters
	always_comb begin
		row_d = row_q;
		line_d = line_q;
		// Field start wins; coincident edges are not expected
		if (vs_edge) begin
			row_d = top_q;
			line_d = offs_q;
		end else if (hs_edge) begin
			if (line_q == lpr) begin
				line_d = 4'h0;
				row_d = next_row(row_q, first_row, last_row);
			end else begin
				line_d = line_q + 4'h1;
			end
		end
	end

	// Counter and sync registers
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			row_q <= 4'h0;
			line_q <= 4'h0;
			hs_q <= 1'b0;
			vs_q <= 1'b0;
		end else begin
			row_q <= row_d;
			line_q <= line_d;
			hs_q <= hsync;
			vs_q <= vsync;
		end
	end

	// Attribute render stage
	always_comb begin
		after_dbl_d = after_dbl_q;
		pix_d = pix_q;
		pix_d.valid = char_valid;
		if (char_valid) begin
			// Character after a double attribute loses its colour
			pix_d.fg = after_dbl_q ? dflt_fg : char_in.fg;
			after_dbl_d = char_in.is_attr & (char_in.dbl_size | char_in.dbl_width);
			// North shadow on the last line, underline or not
			pix_d.north_shadow = char_in.dbl_height & char_in.shadow & (line_q == lpr);
			pix_d.underline = char_in.underline & (line_q == lpr);
		end
		// Each new line starts with a clean attribute chain
		if (hs_edge) begin
			after_dbl_d = 1'b0;
		end
	end

	// Render registers
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			after_dbl_q <= 1'b0;
			pix_q <= '0;
		end else begin
			after_dbl_q <= after_dbl_d;
			pix_q <= pix_d;
		end
	end

	// Outputs straight from flip-flops
	assign prdata = prdata_q;
	assign pready = pready_q;
	assign pslverr = pslverr_q;
	assign disp_row = row_q;
	assign disp_line = line_q;
	assign scroll_active = active_q;
	assign pix_out = pix_q;

endmodule : osdsc_top

//--- verif/osdsc_monitor.sv
// Port assertions for the soft-scroll block
`timescale 1ns/1ps
module osdsc_monitor (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst,
	// APB
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	// Sync and render
	input wire logic hsync,
	input wire logic vsync,
	input wire logic char_valid,
	input wire osdsc_pkg::osdsc_char_type char_in,
	input wire logic scroll_active,
	input wire osdsc_pkg::osdsc_pix_type pix_out
);
	localparam logic [3:0] DEF_FG = 4'hF; // Bench never moves the default colour
	logic hs_q, dbl_q, dbl_d; // Last hsync, double attribute seen
	// Chain breaks on a new line
	always_comb begin
		dbl_d = dbl_q;
		if (hsync && !hs_q) begin
			dbl_d = 1'b0;
		end else if (char_valid) begin
			dbl_d = char_in.is_attr & (char_in.dbl_size | char_in.dbl_width);
		end
	end
	// Registers only
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			hs_q <= 1'b0;
			dbl_q <= 1'b0;
		end else begin
			hs_q <= hsync;
			dbl_q <= dbl_d;
		end
	end
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (rst);
	sequence s_wait; psel && penable && !pready; endsequence
	sequence s_stop; pready && pwrite && paddr == 12'h000 && pwdata == 32'h20 && scroll_active && !vsync; endsequence
	a_one_wait: assert property (s_wait |=> pready)
		else $error("no answer after one wait state");
	a_status_read: assert property (pready && !pwrite && paddr == 12'h000 |-> prdata[31:4] == {27'h0, $past(scroll_active)})
		else $error("status flag read wrong");
	a_stop_defers: assert property (s_stop |=> scroll_active)
		else $error("stop took effect before field end");
	a_fall_tick: assert property ($fell(scroll_active) |-> $past(vsync) || $past(vsync, 2))
		else $error("active flag fell without a field edge");
	a_pix_next: assert property (1'b1 |=> pix_out.valid == $past(char_valid))
		else $error("pixel valid not one cycle after char");
	a_dbl_fg: assert property (char_valid && dbl_q && !hsync |=> pix_out.fg == DEF_FG)
		else $error("colour after double attribute not ignored");
	a_plain_fg: assert property (char_valid && !dbl_q && !hsync |=> pix_out.fg == $past(char_in.fg))
		else $error("own colour lost");
	a_shadow_src: assert property (pix_out.north_shadow |-> $past(char_in.dbl_height && char_in.shadow))
		else $error("shadow without cause");
endmodule : osdsc_monitor
bind osdsc_top osdsc_monitor u_osdsc_monitor (.core_clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata,
	.prdata, .pready, .hsync, .vsync, .char_valid, .char_in, .scroll_active, .pix_out);

//--- verif/osdsc_sync_model.sv
// Video sync source pacing lines and fields
`timescale 1ns/1ps
module osdsc_sync_model (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst,
	// Sync levels
	output logic hsync,
	output logic vsync
);
	logic [7:0] cnt_q, cnt_d; // Position in a 160-clock field
	// Wrap each field
	always_comb begin
		cnt_d = (cnt_q == 8'd159) ? 8'h00 : cnt_q + 8'h01;
	end
	// Registers only
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			cnt_q <= 8'h00;
		end else begin
			cnt_q <= cnt_d;
		end
	end
	// Vsync rises mid-line so the two edges never meet
	assign hsync = (cnt_q % 8'd20) < 8'h02;
	assign vsync = cnt_q >= 8'h0A && cnt_q < 8'h0E;
endmodule : osdsc_sync_model

//--- verif/osdsc_tb_top.sv
// Self-checking bench for the soft-scroll block
`timescale 1ns/1ps
module osdsc_tb_top;
	logic core_clk = 1'b0, rst = 1'b1; // Clock and reset
	logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0; // APB controls
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, r;
	logic pready, pslverr, e, hsync, vsync, scroll_active;
	logic char_valid = 1'b0;
	osdsc_pkg::osdsc_char_type char_in = '0;
	osdsc_pkg::osdsc_pix_type pix_out;
	logic [3:0] disp_row, disp_line;
	int num_errors = 0, n_tests = 0;
	always #5 core_clk = ~core_clk;
	osdsc_top u_osdsc_top (.core_clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
		.pslverr, .hsync, .vsync, .char_valid, .char_in, .disp_row, .disp_line, .scroll_active, .pix_out);
	osdsc_sync_model u_osdsc_sync_model (.core_clk, .rst, .hsync, .vsync);
	// Verdict and end of run
	task automatic complete_run();
		if (num_errors == 0 && n_tests > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : complete_run
	// Compare seen against expected
	task automatic chk(input logic [32:0] s, input logic [32:0] x);
		n_tests++;
		if (s !== x) begin
			num_errors++;
			$display("mismatch at %0t: seen %h expected %h", $time, s, x);
		end
	endtask : chk
	// One APB transfer, held until pready
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] q,
		output logic er);
		int i;
		@(posedge core_clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge core_clk);
		penable <= 1'b1;
		i = 0;
		do begin
			@(posedge core_clk);
			i++;
		end while (pready !== 1'b1 && i < 50);
		q = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (i >= 50) begin
			num_errors++;
			complete_run();
		end
	endtask : apb
	// Read and compare, no error expected
	task automatic rd(input logic [11:0] a, input logic [31:0] x);
		apb(1'b0, a, 32'h0, r, e);
		chk({e, r}, {1'b0, x});
	endtask : rd
	// Wait for a sync rising edge, bounded
	task automatic sync_wait(input logic v);
		int i;
		i = 0;
		while ((v ? vsync : hsync) !== 1'b0 && i < 400) begin
			@(posedge core_clk);
			i++;
		end
		while ((v ? vsync : hsync) !== 1'b1 && i < 400) begin
			@(posedge core_clk);
			i++;
		end
		if (i >= 400) begin
			num_errors++;
			complete_run();
		end
	endtask : sync_wait
	// One character, then its colour, shadow and underline
	task automatic put(input logic [9:0] c, input logic [5:0] x);
		@(posedge core_clk);
		char_valid <= 1'b1;
		char_in <= osdsc_pkg::osdsc_char_type'(c);
		@(posedge core_clk);
		char_valid <= 1'b0;
		@(posedge core_clk);
		chk({27'h0, pix_out.fg, pix_out.north_shadow, pix_out.underline}, {27'h0, x});
	endtask : put
	// Main sequence; field pacing with one line per row, then frame pacing with two
	initial begin
		repeat (10) @(posedge core_clk);
		rst <= 1'b0;
		rd(12'h000, 32'h00);
		rd(12'h004, 32'h0F09);
		rd(12'h008, 32'hF0);
		rd(12'h00C, 32'h00);
		apb(1'b0, 12'h010, 32'h0, r, e);
		chk({e, r}, {1'b1, 32'h0});
		apb(1'b1, 12'h004, 32'hFFFF_FFE0, r, e);
		rd(12'h004, 32'h0F00);
		apb(1'b1, 12'h008, 32'hFFFF_FF50, r, e);
		rd(12'h008, 32'h50);
		apb(1'b1, 12'h000, 32'h40, r, e);
		rd(12'h000, 32'h10);
		sync_wait(1'b1);
		rd(12'h000, 32'h11);
		sync_wait(1'b1);
		rd(12'h000, 32'h01);
		apb(1'b1, 12'h000, 32'h82, r, e);
		apb(1'b1, 12'h000, 32'h40, r, e);
		rd(12'h000, 32'h12);
		apb(1'b1, 12'h000, 32'h20, r, e);
		rd(12'h000, 32'h12);
		apb(1'b1, 12'h000, 32'h40, r, e);
		sync_wait(1'b1);
		rd(12'h000, 32'h03);
		sync_wait(1'b1);
		sync_wait(1'b0);
		put(10'h30F, 6'h3C);
		chk({25'h0, disp_row, disp_line}, {25'h0, 8'h40});
		put(10'h003, 6'h3C);
		put(10'h003, 6'h0C);
		put(10'h28F, 6'h3C);
		put(10'h005, 6'h3C);
		sync_wait(1'b0);
		put(10'h063, 6'h0E);
		put(10'h073, 6'h0F);
		apb(1'b1, 12'h000, 32'h40, r, e);
		rd(12'h000, 32'h13);
		// Display row wraps from the last row of the range to the first
		sync_wait(1'b0);
		@(posedge core_clk);
		chk({25'h0, disp_row, disp_line}, {25'h0, 8'h00});
		sync_wait(1'b1);
		rd(12'h000, 32'h14);
		sync_wait(1'b1);
		rd(12'h000, 32'h04);
		// Frame pacing, two lines per row
		apb(1'b1, 12'h004, 32'h0000_0F11, r, e);
		apb(1'b1, 12'h000, 32'h40, r, e);
		sync_wait(1'b1);
		rd(12'h00C, 32'h01);
		sync_wait(1'b1);
		rd(12'h000, 32'h14);
		chk({25'h0, disp_row, disp_line}, {25'h0, 8'h41});
		sync_wait(1'b0);
		put(10'h063, 6'h0C);
		sync_wait(1'b0);
		put(10'h063, 6'h0E);
		sync_wait(1'b1);
		rd(12'h000, 32'h15);
		complete_run();
	end
endmodule : osdsc_tb_top
